// file: verilog/pmc_top.sv
// power monitor control: i2c target, conversion sequencer, averaging, alert
// assumes straps arrive pre-classified (0 gnd, 1 supply, 2 sda, 3 scl)
// and converter words on shunt_adc_i / bus_adc_i are stable at timer end
`timescale 1ns/1ps
module pmc_top (
  // core clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // link sample clock for the i2c front end
  input wire logic link_clk_i,
  // i2c pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // address straps
  input wire logic [1:0] address_strap_low_i,
  input wire logic [1:0] address_strap_high_i,
  // converter
  input wire logic [15:0] shunt_adc_i,
  input wire logic [15:0] bus_adc_i,
  output logic adc_bus_sel_o,
  output logic conv_busy_o,
  // alert pin
  output logic alert_o
);
  ////////////////////////////////////////////////////////////////////////
  // link domain
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  logic [1:0] stl_s1, stl_s2, sth_s1, sth_s2;
  logic ack_s1, ack_s2, ack_s3;
  pmc_pkg::pmc_i2c_e i_st_reg, i_st_next;
  logic [6:0] addr_reg, addr_next;
  logic addr_ok_reg, addr_ok_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next, msb_reg, msb_next;
  logic [1:0] idx_reg, idx_next;
  logic rw_reg, rw_next, half_reg, half_next, sda_oe_reg, sda_oe_next;
  logic [2:0] ptr_reg, ptr_next, req_ptr_reg, req_ptr_next;
  logic [15:0] rd_word_reg, rd_word_next, req_dat_reg, req_dat_next;
  logic req_tgl_reg, req_tgl_next, req_wr_reg, req_wr_next;
  logic rise, fall, start, stop;
  logic [7:0] tx_byte;
  // core side words read by the link after the ack toggle settles
  logic [15:0] rsp_dat_reg;
  logic ack_tgl_reg;

  assign rise = scl_s2 & ~scl_s3;
  assign fall = ~scl_s2 & scl_s3;
  assign start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  assign tx_byte = half_reg ? rd_word_reg[7:0] : rd_word_reg[15:8];

  always_comb begin
    i_st_next = i_st_reg;
    addr_next = addr_reg;
    addr_ok_next = 1'b1;
    bit_next = bit_reg;
    sh_next = sh_reg;
    msb_next = msb_reg;
    idx_next = idx_reg;
    rw_next = rw_reg;
    half_next = half_reg;
    sda_oe_next = sda_oe_reg;
    ptr_next = ptr_reg;
    rd_word_next = rd_word_reg;
    req_tgl_next = req_tgl_reg;
    req_wr_next = req_wr_reg;
    req_ptr_next = req_ptr_reg;
    req_dat_next = req_dat_reg;
    // straps are static; following the synchronised copy keeps the reset
    // zeros of the synchroniser out of the address
    addr_next = {pmc_pkg::ADDR_BASE, sth_s2, stl_s2};
    if (ack_s2 ^ ack_s3) begin
      rd_word_next = rsp_dat_reg;
    end
    if (start) begin
      i_st_next = pmc_pkg::I_RX;
      bit_next = 4'h0;
      idx_next = 2'h0;
      sda_oe_next = 1'b0;
    end else if (stop) begin
      i_st_next = pmc_pkg::I_IDLE;
      sda_oe_next = 1'b0;
    end else begin
      unique case (i_st_reg)
        pmc_pkg::I_IDLE: begin
        end
        pmc_pkg::I_RX: begin
          if (rise) begin
            sh_next = {sh_reg[6:0], sda_s2};
            bit_next = bit_reg + 4'h1;
          end else if (fall && bit_reg == 4'h8) begin
            bit_next = 4'h0;
            i_st_next = pmc_pkg::I_ACK;
            sda_oe_next = 1'b1;
            unique case (idx_reg)
              2'h0: begin
                if (sh_reg[7:1] != addr_reg) begin
                  i_st_next = pmc_pkg::I_IDLE;
                  sda_oe_next = 1'b0;
                end else begin
                  rw_next = sh_reg[0];
                  half_next = 1'b0;
                  idx_next = 2'h1;
                  if (sh_reg[0]) begin
                    req_tgl_next = ~req_tgl_reg;
                    req_wr_next = 1'b0;
                    req_ptr_next = ptr_reg;
                  end
                end
              end
              2'h1: begin
                ptr_next = sh_reg[2:0];
                idx_next = 2'h2;
              end
              2'h2: begin
                msb_next = sh_reg;
                idx_next = 2'h3;
              end
              2'h3: begin
                req_tgl_next = ~req_tgl_reg;
                req_wr_next = 1'b1;
                req_ptr_next = ptr_reg;
                req_dat_next = {msb_reg, sh_reg};
                idx_next = 2'h2;
              end
            endcase
          end
        end
        pmc_pkg::I_ACK: begin
          if (fall) begin
            if (rw_reg) begin
              i_st_next = pmc_pkg::I_TX;
              sh_next = tx_byte;
              sda_oe_next = ~tx_byte[7];
              bit_next = 4'h1;
            end else begin
              i_st_next = pmc_pkg::I_RX;
              sda_oe_next = 1'b0;
            end
          end
        end
        pmc_pkg::I_TX: begin
          if (fall) begin
            if (bit_reg == 4'h8) begin
              i_st_next = pmc_pkg::I_RACK;
              sda_oe_next = 1'b0;
              half_next = ~half_reg;
              // refetch after the low byte so the next word is fresh
              if (half_reg) begin
                req_tgl_next = ~req_tgl_reg;
                req_wr_next = 1'b0;
                req_ptr_next = ptr_reg;
              end
            end else begin
              sh_next = {sh_reg[6:0], 1'b0};
              sda_oe_next = ~sh_reg[6];
              bit_next = bit_reg + 4'h1;
            end
          end
        end
        pmc_pkg::I_RACK: begin
          if (rise) begin
            sh_next[0] = sda_s2;
          end else if (fall) begin
            if (!sh_reg[0]) begin
              i_st_next = pmc_pkg::I_TX;
              sh_next = tx_byte;
              sda_oe_next = ~tx_byte[7];
              bit_next = 4'h1;
            end else begin
              i_st_next = pmc_pkg::I_IDLE;
            end
          end
        end
        default: begin
          i_st_next = pmc_pkg::I_IDLE;
          sda_oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3} <= 6'h3f;
      {stl_s1, stl_s2, sth_s1, sth_s2} <= 8'h00;
      {ack_s1, ack_s2, ack_s3} <= 3'h0;
      i_st_reg <= pmc_pkg::I_IDLE;
      addr_reg <= 7'h00;
      addr_ok_reg <= 1'b0;
      bit_reg <= 4'h0;
      {sh_reg, msb_reg} <= 16'h0000;
      idx_reg <= 2'h0;
      {rw_reg, half_reg, sda_oe_reg} <= 3'h0;
      {ptr_reg, req_ptr_reg} <= 6'h00;
      rd_word_reg <= 16'h0000;
      req_dat_reg <= 16'h0000;
      {req_tgl_reg, req_wr_reg} <= 2'h0;
      sda_o <= 1'b0;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
      {stl_s1, stl_s2} <= {address_strap_low_i, stl_s1};
      {sth_s1, sth_s2} <= {address_strap_high_i, sth_s1};
      {ack_s1, ack_s2, ack_s3} <= {ack_tgl_reg, ack_s1, ack_s2};
      i_st_reg <= i_st_next;
      addr_reg <= addr_next;
      addr_ok_reg <= addr_ok_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      msb_reg <= msb_next;
      idx_reg <= idx_next;
      rw_reg <= rw_next;
      half_reg <= half_next;
      sda_oe_reg <= sda_oe_next;
      ptr_reg <= ptr_next;
      rd_word_reg <= rd_word_next;
      req_tgl_reg <= req_tgl_next;
      req_wr_reg <= req_wr_next;
      req_ptr_reg <= req_ptr_next;
      req_dat_reg <= req_dat_next;
      sda_o <= 1'b0;
    end
  end
  assign sda_oe_o = sda_oe_reg;

  a_addr_base: assert property (@(posedge link_clk_i) disable iff (rst_i)
    addr_ok_reg |-> addr_reg == {pmc_pkg::ADDR_BASE, $past(sth_s2), $past(stl_s2)})
    else $error("address does not follow the straps");

  ////////////////////////////////////////////////////////////////////////
  // core domain
  logic req_s1, req_s2, req_s3, apply, mode_wr;
  pmc_pkg::pmc_conv_e c_st_reg, c_st_next, first_ch;
  logic [15:0] cfg_reg, cfg_next, cal_reg, cal_next, mask_reg, mask_next;
  logic [15:0] lim_reg, lim_next, rsp_next;
  logic [15:0] sh_res_reg, sh_res_next, bus_res_reg, bus_res_next;
  logic [15:0] cur_res_reg, cur_res_next, pwr_res_reg, pwr_res_next;
  logic cvrf_reg, cvrf_next, aff_reg, aff_next, ack_tgl_next;
  logic [10:0] tmr_reg, tmr_next, smp_reg, smp_next;
  logic signed [26:0] acc_sh_reg, acc_sh_next;
  logic [25:0] acc_bus_reg, acc_bus_next;
  logic alert_next, busy_next, bus_sel_next, alert_act, cmp;
  logic signed [26:0] sh_shift;
  logic [25:0] bus_shift;
  logic signed [15:0] sh_avg, cur_val;
  logic [15:0] bus_avg;
  logic signed [32:0] cur_prod, pwr_prod;
  logic [2:0] avg_code, mode;

  assign apply = req_s2 ^ req_s3;
  assign mode_wr = apply & req_wr_reg & (req_ptr_reg == pmc_pkg::PTR_CFG);
  assign avg_code = cfg_reg[pmc_pkg::CFG_AVG_LSB +: 3];
  assign mode = cfg_reg[2:0];
  assign first_ch = mode[0] ? pmc_pkg::C_SHUNT : pmc_pkg::C_BUS;
  assign sh_shift = acc_sh_reg >>> pmc_pkg::AVG_SHIFT[avg_code];
  assign bus_shift = acc_bus_reg >> pmc_pkg::AVG_SHIFT[avg_code];
  assign sh_avg = sh_shift[15:0];
  assign bus_avg = bus_shift[15:0];
  assign cur_prod = sh_avg * $signed({1'b0, cal_reg});
  assign cur_val = cur_prod[pmc_pkg::CURRENT_LSB_BIT +: 16];
  assign pwr_prod = cur_val * $signed({1'b0, bus_avg});
  assign alert_act = aff_reg | (mask_reg[pmc_pkg::MASK_CNVR_BIT] & cvrf_reg);

  always_comb begin
    unique case (mask_reg[pmc_pkg::MASK_SEL_LSB +: 3])
      pmc_pkg::SEL_SH_OVER: cmp = sh_avg > $signed(lim_reg);
      pmc_pkg::SEL_SH_UNDER: cmp = sh_avg < $signed(lim_reg);
      pmc_pkg::SEL_BUS_OVER: cmp = bus_avg > lim_reg;
      pmc_pkg::SEL_BUS_UNDER: cmp = bus_avg < lim_reg;
      pmc_pkg::SEL_PWR_OVER: cmp = mode[1:0] == 2'h3 && pwr_prod[27:12] > lim_reg;
      default: cmp = 1'b0;
    endcase
  end

  always_comb begin
    c_st_next = c_st_reg;
    cfg_next = cfg_reg;
    cal_next = cal_reg;
    mask_next = mask_reg;
    lim_next = lim_reg;
    rsp_next = rsp_dat_reg;
    ack_tgl_next = ack_tgl_reg;
    {sh_res_next, bus_res_next} = {sh_res_reg, bus_res_reg};
    {cur_res_next, pwr_res_next} = {cur_res_reg, pwr_res_reg};
    cvrf_next = cvrf_reg;
    aff_next = aff_reg;
    tmr_next = tmr_reg;
    smp_next = smp_reg;
    acc_sh_next = acc_sh_reg;
    acc_bus_next = acc_bus_reg;
    unique case (c_st_reg)
      pmc_pkg::C_IDLE: begin
      end
      pmc_pkg::C_SHUNT: begin
        tmr_next = tmr_reg - 11'h1;
        if (tmr_reg == 11'h0) begin
          acc_sh_next = acc_sh_reg + 27'(signed'(shunt_adc_i));
          c_st_next = mode[1] ? pmc_pkg::C_BUS : pmc_pkg::C_SHUNT;
          tmr_next = mode[1] ? pmc_pkg::ct_load(cfg_reg[pmc_pkg::CFG_BUSCT_LSB +: 3])
                             : pmc_pkg::ct_load(cfg_reg[pmc_pkg::CFG_SHCT_LSB +: 3]);
          if (!mode[1]) begin
            smp_next = smp_reg + 11'h1;
            c_st_next = smp_reg == pmc_pkg::avg_last(avg_code) ? pmc_pkg::C_DONE
                                                               : pmc_pkg::C_SHUNT;
          end
        end
      end
      pmc_pkg::C_BUS: begin
        tmr_next = tmr_reg - 11'h1;
        if (tmr_reg == 11'h0) begin
          acc_bus_next = acc_bus_reg + 26'(bus_adc_i);
          smp_next = smp_reg + 11'h1;
          c_st_next = smp_reg == pmc_pkg::avg_last(avg_code) ? pmc_pkg::C_DONE : first_ch;
          tmr_next = mode[0] ? pmc_pkg::ct_load(cfg_reg[pmc_pkg::CFG_SHCT_LSB +: 3])
                             : pmc_pkg::ct_load(cfg_reg[pmc_pkg::CFG_BUSCT_LSB +: 3]);
        end
      end
      pmc_pkg::C_DONE: begin
        if (mode[0]) sh_res_next = sh_avg;
        if (mode[1]) bus_res_next = bus_avg;
        // derived values only make sense with both channels measured
        if (mode[1:0] == 2'h3) begin
          cur_res_next = cur_val;
          pwr_res_next = pwr_prod[pmc_pkg::POWER_LSB_BIT +: 16];
        end
        aff_next = cmp;
        smp_next = 11'h0;
        acc_sh_next = '0;
        acc_bus_next = '0;
        c_st_next = mode[2] ? first_ch : pmc_pkg::C_IDLE;
        tmr_next = pmc_pkg::ct_load(cfg_reg[(mode[0] ? pmc_pkg::CFG_SHCT_LSB
                                                     : pmc_pkg::CFG_BUSCT_LSB) +: 3]);
      end
    endcase
    if (apply && !req_wr_reg) begin
      unique case (req_ptr_reg)
        pmc_pkg::PTR_CFG: rsp_next = cfg_reg;
        pmc_pkg::PTR_SHUNT: rsp_next = sh_res_reg;
        pmc_pkg::PTR_BUS: rsp_next = bus_res_reg;
        pmc_pkg::PTR_POWER: rsp_next = pwr_res_reg;
        pmc_pkg::PTR_CURRENT: rsp_next = cur_res_reg;
        pmc_pkg::PTR_CAL: rsp_next = cal_reg;
        pmc_pkg::PTR_MASK: rsp_next = mask_reg | 16'(aff_reg) << pmc_pkg::MASK_AFF_BIT |
                                      16'(cvrf_reg) << pmc_pkg::MASK_CVRF_BIT;
        pmc_pkg::PTR_LIMIT: rsp_next = lim_reg;
      endcase
      if (req_ptr_reg == pmc_pkg::PTR_MASK) cvrf_next = 1'b0;
      ack_tgl_next = ~ack_tgl_reg;
    end
    if (apply && req_wr_reg) begin
      unique case (req_ptr_reg)
        pmc_pkg::PTR_CAL: cal_next = req_dat_reg;
        pmc_pkg::PTR_MASK: mask_next = req_dat_reg & pmc_pkg::MASK_WR_BITS;
        pmc_pkg::PTR_LIMIT: lim_next = req_dat_reg;
        default: begin
        end
      endcase
    end
    if (mode_wr) begin
      // any mode write aborts the running sequence; it restarts unless the write selects power-down or soft reset
      cfg_next = req_dat_reg[pmc_pkg::CFG_SRST_BIT] ? pmc_pkg::CFG_RESET : req_dat_reg;
      c_st_next = pmc_pkg::C_IDLE;
      if (!req_dat_reg[pmc_pkg::CFG_SRST_BIT] && req_dat_reg[1:0] != 2'h0) begin
        c_st_next = req_dat_reg[0] ? pmc_pkg::C_SHUNT : pmc_pkg::C_BUS;
      end
      tmr_next = pmc_pkg::ct_load(req_dat_reg[(req_dat_reg[0] ? pmc_pkg::CFG_SHCT_LSB
                                                              : pmc_pkg::CFG_BUSCT_LSB) +: 3]);
      smp_next = 11'h0;
      acc_sh_next = '0;
      acc_bus_next = '0;
      if (req_dat_reg[pmc_pkg::CFG_SRST_BIT]) begin
        {cal_next, mask_next, lim_next} = {3{pmc_pkg::WORD_RESET}};
        {sh_res_next, bus_res_next, cur_res_next, pwr_res_next} = '0;
        aff_next = 1'b0;
        cvrf_next = 1'b0;
      end
    end
    // a sequence end in the same cycle as a clearing read keeps the flag
    if (c_st_reg == pmc_pkg::C_DONE && !mode_wr) cvrf_next = 1'b1;
    busy_next = c_st_next == pmc_pkg::C_SHUNT || c_st_next == pmc_pkg::C_BUS;
    bus_sel_next = c_st_next == pmc_pkg::C_BUS;
    alert_next = mask_reg[pmc_pkg::MASK_POL_BIT] ? alert_act : ~alert_act;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {req_s1, req_s2, req_s3} <= 3'h0;
      c_st_reg <= pmc_pkg::C_IDLE;
      cfg_reg <= pmc_pkg::CFG_RESET;
      {cal_reg, mask_reg, lim_reg} <= {3{pmc_pkg::WORD_RESET}};
      {sh_res_reg, bus_res_reg, cur_res_reg, pwr_res_reg} <= '0;
      rsp_dat_reg <= 16'h0000;
      {ack_tgl_reg, cvrf_reg, aff_reg} <= 3'h0;
      {tmr_reg, smp_reg} <= 22'h0;
      acc_sh_reg <= '0;
      acc_bus_reg <= '0;
      {conv_busy_o, adc_bus_sel_o} <= 2'h0;
      alert_o <= 1'b1;
    end else begin
      {req_s1, req_s2, req_s3} <= {req_tgl_reg, req_s1, req_s2};
      c_st_reg <= c_st_next;
      cfg_reg <= cfg_next;
      cal_reg <= cal_next;
      mask_reg <= mask_next;
      lim_reg <= lim_next;
      {sh_res_reg, bus_res_reg} <= {sh_res_next, bus_res_next};
      {cur_res_reg, pwr_res_reg} <= {cur_res_next, pwr_res_next};
      rsp_dat_reg <= rsp_next;
      ack_tgl_reg <= ack_tgl_next;
      cvrf_reg <= cvrf_next;
      aff_reg <= aff_next;
      tmr_reg <= tmr_next;
      smp_reg <= smp_next;
      acc_sh_reg <= acc_sh_next;
      acc_bus_reg <= acc_bus_next;
      conv_busy_o <= busy_next;
      adc_bus_sel_o <= bus_sel_next;
      alert_o <= alert_next;
    end
  end

  a_trig_stops: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (c_st_reg == pmc_pkg::C_DONE && !mode[2] && !mode_wr) |=> c_st_reg == pmc_pkg::C_IDLE)
    else $error("triggered mode converted again");
  a_cont_restart: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (c_st_reg == pmc_pkg::C_DONE && mode[2] && mode[1:0] != 2'h0 && !mode_wr)
    |=> c_st_reg inside {pmc_pkg::C_SHUNT, pmc_pkg::C_BUS})
    else $error("continuous mode did not restart");
  a_pd_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (c_st_reg == pmc_pkg::C_IDLE && mode[1:0] == 2'h0 && !mode_wr)[*2] |-> !conv_busy_o)
    else $error("conversion in power-down");
  a_mode_abort: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mode_wr |=> smp_reg == 11'h0 && acc_sh_reg == '0 && acc_bus_reg == '0
    && c_st_reg != pmc_pkg::C_DONE)
    else $error("mode write did not restart");
  a_cvrf_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (c_st_reg == pmc_pkg::C_DONE && !mode_wr) |=> cvrf_reg)
    else $error("ready flag not set at sequence end");
  a_alert_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!mask_reg[pmc_pkg::MASK_POL_BIT] && aff_reg && !mode_wr) |=> !alert_o)
    else $error("active-low alert not driven low");
  a_ready_alert: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (c_st_reg == pmc_pkg::C_DONE && mask_reg[pmc_pkg::MASK_CNVR_BIT] && !mode_wr
     && $stable(mask_reg)) |=> ##1 alert_o == mask_reg[pmc_pkg::MASK_POL_BIT])
    else $error("ready alert missing");
  a_derived_both: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (c_st_reg == pmc_pkg::C_DONE && mode[1:0] != 2'h3 && !mode_wr) |=> $stable(cur_res_reg))
    else $error("current updated without both channels");
endmodule : pmc_top

// file: verilog/pmc_pkg.sv
// constants and types of the power monitor control block
// assumes a 10 MHz core clock; the i2c front end runs on its own link clock
//
// Operation
// - i2c address is 100 then high strap code then low strap code
// - triggered mode converts once per mode write, then waits
// - continuous mode restarts a sequence as soon as one ends
// - power-down mode converts nothing until another mode is written
// - mode picks shunt, bus or both; current and power need both
// - results are the average of the chosen number of samples
// - shunt and bus conversion times are set separately
// - selected measurement beyond the limit raises alert flag and pin
// - alert pin is active low after reset until polarity changes
// - with ready alert enabled, sequence end asserts the alert pin
// - ready flag and alert flag are readable over i2c
package pmc_pkg;
  localparam int CORE_CLK_MHZ = 10;
  // register pointers
  localparam logic [2:0] PTR_CFG = 3'h0;
  localparam logic [2:0] PTR_SHUNT = 3'h1;
  localparam logic [2:0] PTR_BUS = 3'h2;
  localparam logic [2:0] PTR_POWER = 3'h3;
  localparam logic [2:0] PTR_CURRENT = 3'h4;
  localparam logic [2:0] PTR_CAL = 3'h5;
  localparam logic [2:0] PTR_MASK = 3'h6;
  localparam logic [2:0] PTR_LIMIT = 3'h7;
  // reset values
  localparam logic [15:0] CFG_RESET = 16'h4127;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // field positions
  localparam int CFG_SRST_BIT = 15;
  localparam int CFG_AVG_LSB = 9;
  localparam int CFG_BUSCT_LSB = 6;
  localparam int CFG_SHCT_LSB = 3;
  localparam int MASK_SEL_LSB = 13;
  localparam int MASK_CNVR_BIT = 10;
  localparam int MASK_AFF_BIT = 4;
  localparam int MASK_CVRF_BIT = 3;
  localparam int MASK_POL_BIT = 1;
  localparam logic [15:0] MASK_WR_BITS = 16'he402;
  // address upper bits
  localparam logic [2:0] ADDR_BASE = 3'h4;
  // alert source select codes
  localparam logic [2:0] SEL_SH_OVER = 3'h1;
  localparam logic [2:0] SEL_SH_UNDER = 3'h2;
  localparam logic [2:0] SEL_BUS_OVER = 3'h3;
  localparam logic [2:0] SEL_BUS_UNDER = 3'h4;
  localparam logic [2:0] SEL_PWR_OVER = 3'h5;
  // conversion times per code in microseconds, and averaging shifts
  localparam int CT_US [8] = '{1, 2, 4, 8, 16, 32, 64, 128};
  localparam int AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
  localparam int CURRENT_LSB_BIT = 11;
  localparam int POWER_LSB_BIT = 12;

  typedef enum logic [1:0] {
    C_IDLE = 2'b00, C_SHUNT = 2'b01, C_BUS = 2'b10, C_DONE = 2'b11
  } pmc_conv_e;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000, I_RX = 3'b001, I_ACK = 3'b010, I_TX = 3'b011, I_RACK = 3'b100
  } pmc_i2c_e;

  function automatic logic [10:0] ct_load(input logic [2:0] code);
    ct_load = 11'(CT_US[code] * CORE_CLK_MHZ - 1);
  endfunction : ct_load

  function automatic logic [10:0] avg_last(input logic [2:0] code);
    avg_last = 11'((1 << AVG_SHIFT[code]) - 1);
  endfunction : avg_last
endpackage : pmc_pkg

// file: testbench/pmc_i2c_host.sv
// i2c bus controller model: start, stop and nine-bit byte slots
// assumes the target never stretches scl; sda has a pull-up
`timescale 1ns/1ps
module pmc_i2c_host (
  // target side of the data pin
  input wire logic sda_oe_i,
  // bus lines
  output logic scl_o,
  output logic sda_o
);
  logic pull_low;
  // open drain: a released line reads high through the pull-up
  assign sda_o = !(pull_low || sda_oe_i);
  initial begin
    scl_o = 1'b1;
    pull_low = 1'b0;
  end
  task automatic start_cond;
    pull_low = 1'b1;
    #1000 scl_o = 1'b0;
    #1000;
  endtask : start_cond
  task automatic stop_cond;
    #200 pull_low = 1'b1;
    #1000 scl_o = 1'b1;
    #1000 pull_low = 1'b0;
    #2000;
  endtask : stop_cond
  // data moves away from the scl fall so it is never mistaken for start or stop
  task automatic slot9(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      #200 pull_low = !d[i];
      #800 scl_o = 1'b1;
      #1000 q[i] = sda_o;
      scl_o = 1'b0;
    end
  endtask : slot9
endmodule : pmc_i2c_host

// file: testbench/pmc_top_test.sv
// self-checking bench of the power monitor control block
// assumes converter words that change only between runs and an i2c host model on the pins
`timescale 1ns/1ps
module pmc_top_test;
  localparam logic [6:0] DEV = 7'h49;
  logic core_clk_i = 1'b0, rst_i = 1'b1, link_clk_i = 1'b0, scl, sda, sda_o, sda_oe, bus_sel;
  logic busy, alert_o, ok;
  logic [1:0] strap_lo = 2'h1, strap_hi = 2'h2;
  logic [15:0] shunt_adc = 16'h0100, bus_adc = 16'h0200, val;
  int mismatches = 0, samples_checked = 0, cycles = 0, slots = 0, busy_cyc = 0, bus_cyc = 0;
  always #50 core_clk_i = ~core_clk_i;
  initial begin
    #3.7;
    forever #6 link_clk_i = ~link_clk_i;
  end
  always @(posedge bus_sel) slots++;
  always @(posedge core_clk_i) begin
    busy_cyc += busy;
    bus_cyc += bus_sel;
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      stop_test();
    end
  end
  pmc_top u_pmc_top (.core_clk_i(core_clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .address_strap_low_i(strap_lo), .address_strap_high_i(strap_hi),
    .shunt_adc_i(shunt_adc), .bus_adc_i(bus_adc), .adc_bus_sel_o(bus_sel),
    .conv_busy_o(busy), .alert_o(alert_o));
  pmc_i2c_host u_pmc_i2c_host (.sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr_word(input logic [6:0] a, input logic [7:0] p, input logic [15:0] v);
    logic [8:0] q0, q1, q2, q3;
    u_pmc_i2c_host.start_cond();
    u_pmc_i2c_host.slot9({a, 2'b01}, q0);
    u_pmc_i2c_host.slot9({p, 1'b1}, q1);
    u_pmc_i2c_host.slot9({v[15:8], 1'b1}, q2);
    u_pmc_i2c_host.slot9({v[7:0], 1'b1}, q3);
    u_pmc_i2c_host.stop_cond();
    ok = !(q0[0] | q1[0] | q2[0] | q3[0]);
  endtask : wr_word
  // pointer write, then a two-byte read ended by a nack
  task automatic rd_word(input logic [7:0] p, input logic [15:0] exp);
    logic [8:0] q0, q1, q2;
    u_pmc_i2c_host.start_cond();
    u_pmc_i2c_host.slot9({DEV, 2'b01}, q0);
    u_pmc_i2c_host.slot9({p, 1'b1}, q0);
    u_pmc_i2c_host.stop_cond();
    u_pmc_i2c_host.start_cond();
    u_pmc_i2c_host.slot9({DEV, 2'b11}, q0);
    u_pmc_i2c_host.slot9(9'h1fe, q1);
    u_pmc_i2c_host.slot9(9'h1ff, q2);
    u_pmc_i2c_host.stop_cond();
    check({q1[8:1], q2[8:1]}, exp);
  endtask : rd_word
  task automatic run_cfg(input logic [15:0] cfg, input int n, input int b, input int u);
    slots = 0;
    busy_cyc = 0;
    bus_cyc = 0;
    wr_word(DEV, 8'h00, cfg);
    repeat (300) @(negedge core_clk_i);
    check(16'(ok), 16'h0001);
    check(16'(slots), 16'(n));
    check(16'(busy_cyc), 16'(b));
    check(16'(bus_cyc), 16'(u));
  endtask : run_cfg
  task automatic stop_test;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge core_clk_i);
    rst_i = 1'b0;
    #1000;
    check(16'(alert_o), 16'h0001);
    check(16'(sda_o), 16'h0000);
    wr_word(7'h40, 8'h00, 16'h0003);
    check(16'(ok), 16'h0000);
    wr_word(DEV, 8'h05, 16'h0800);
    run_cfg(16'h0003, 1, 20, 10);
    run_cfg(16'h0203, 4, 80, 40);
    run_cfg(16'h0043, 1, 30, 20);
    rd_word(8'h04, 16'h0100);
    rd_word(8'h02, 16'h0200);
    run_cfg(16'h0001, 0, 10, 0);
    slots = 0;
    wr_word(DEV, 8'h00, 16'h0007);
    repeat (300) @(negedge core_clk_i);
    check(16'(slots > 4), 16'h0001);
    wr_word(DEV, 8'h00, 16'h01ff);
    wr_word(DEV, 8'h00, 16'h0000);
    repeat (20) @(negedge core_clk_i);
    check(16'(busy), 16'h0000);
    run_cfg(16'h0000, 0, 0, 0);
    wr_word(DEV, 8'h06, 16'h6000);
    wr_word(DEV, 8'h07, 16'h0100);
    run_cfg(16'h0003, 1, 20, 10);
    check(16'(alert_o), 16'h0000);
    rd_word(8'h06, 16'h6018);
    @(negedge core_clk_i) bus_adc = 16'h0050;
    wr_word(DEV, 8'h06, 16'h0400);
    run_cfg(16'h0003, 1, 20, 10);
    check(16'(alert_o), 16'h0000);
    rd_word(8'h06, 16'h0408);
    check(16'(alert_o), 16'h0001);
    // polarity flipped to active high: an idle alert now reads low
    wr_word(DEV, 8'h06, 16'h0402);
    check(16'(alert_o), 16'h0000);
    // soft reset restores the default configuration and polarity
    wr_word(DEV, 8'h00, 16'h8000);
    rd_word(8'h00, 16'h4127);
    check(16'(alert_o), 16'h0001);
    stop_test();
  end
endmodule : pmc_top_test
